// ==== hw/desc_link_if.sv ====
`timescale 1ns/1ps
// Byte stream from section demultiplexer to parser
interface desc_link_if;
  logic valid;
  logic [7:0] data;
  logic start;
  logic broadcast;
  modport source (output valid, output data, output start, output broadcast);
  modport sink (input valid, input data, input start, input broadcast);
endinterface : desc_link_if

// ==== hw/desc_parser.sv ====
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "desc_parser_regs.svh"
// Terminal end: parses return link and table update descriptors
module desc_parser (
  input wire logic clk_in,
  input wire logic rst_n_in,
  desc_link_if.sink link,
  input wire logic update_enable_in,
  output desc_parser_pkg::return_link_t return_link_out,
  output logic return_link_done_out,
  output logic [7:0] private_byte_out,
  output logic private_valid_out,
  output logic [15:0] network_selector_out,
  output logic network_valid_out,
  output logic [7:0] changed_table_code_out,
  output logic [4:0] new_version_out,
  output logic update_valid_out,
  output logic length_error_out
);
  import desc_parser_pkg::*;
  parse_state_t state;
  logic [7:0] kind;
  logic [7:0] remain;
  logic [7:0] idx;
  logic [7:0] first_byte;
  return_link_t rl;
  logic [23:0] shift;
  logic last;
  logic body_byte;
  logic in_body;
  logic rl_byte;
  logic tu_byte;
  // ----------------------------------------
  // Byte qualifiers
  // ----------------------------------------
  // A start byte is never body data, even in the middle of a descriptor
  assign body_byte = link.valid && !link.start;
  assign in_body = (state == ST_RL) || (state == ST_TU) || (state == ST_SKIP) || (state == ST_PRIV);
  assign rl_byte = body_byte && (state == ST_RL);
  assign tu_byte = body_byte && (state == ST_TU);
  // Current byte is the final one the length allows
  assign last = (remain == 8'h01);
  // ----------------------------------------
  // Framing state machine
  // ----------------------------------------
  // Start always resyncs, so a lost byte costs one descriptor only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_KIND;
    end else if (link.valid && link.start) begin
      state <= ST_LEN; // RULE1
    end else if (link.valid) begin
      case (state)
        ST_KIND: begin
          state <= ST_LEN;
        end
        ST_LEN: begin
          if (link.data == 8'h00) begin
            state <= ST_KIND;
          end else if (kind == `KIND_RETURN_LINK) begin
            state <= ST_RL;
          end else if (kind == `KIND_TABLE_UPDATE && update_enable_in) begin
            state <= ST_TU; // RULE15
          end else begin
            state <= ST_SKIP;
          end
        end
        ST_RL, ST_TU, ST_SKIP, ST_PRIV: begin
          if (last) begin
            state <= ST_KIND; // RULE1
          end else if (state == ST_RL && idx == `RL_OFFSET_IDX) begin
            state <= ST_PRIV; // RULE12
          end
        end
        default: begin
          state <= ST_KIND;
        end
      endcase
    end
  end
  // Kind byte, from a start byte or from idle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kind <= 8'h00;
    end else if (link.valid && (link.start || state == ST_KIND)) begin
      kind <= link.data; // RULE1
    end
  end
  // Remaining length and body index; length counts bytes after itself
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain <= 8'h00;
      idx <= 8'h00;
    end else if (body_byte && state == ST_LEN) begin
      remain <= link.data; // RULE1
      idx <= 8'h00;
    end else if (body_byte && in_body) begin
      remain <= remain - 8'h01;
      idx <= idx + 8'h01;
    end
  end
  // Bad lengths flagged once, at the length byte, before any field
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      length_error_out <= 1'b0;
    end else if (body_byte && state == ST_LEN && link.data != 8'h00) begin
      if (kind == `KIND_RETURN_LINK) begin
        length_error_out <= link.data < `RL_FIXED_LEN; // RULE20
      end else if (kind == `KIND_TABLE_UPDATE && update_enable_in) begin
        // Entries are two bytes, so an odd length means a cut entry
        length_error_out <= (link.data < `TU_FIXED_LEN) || link.data[0]; // RULE20
      end else begin
        length_error_out <= 1'b0;
      end
    end else begin
      length_error_out <= 1'b0;
    end
  end
  // ----------------------------------------
  // Return link field capture
  // ----------------------------------------
  // Three-byte window for multi-byte fields, MSB first, no swapping
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift <= 24'h000000;
    end else if (rl_byte) begin
      shift <= {shift[15:0], link.data}; // RULE19
    end
  end
  // Reserved byte and reserved flag bits are never looked at
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rl <= '0;
    end else if (rl_byte) begin
      case (idx)
        `RL_SAT_IDX: rl.spacecraft_selector <= link.data; // RULE2
        `RL_SPOT_IDX: rl.spot_number <= {shift[7:0], link.data}; // RULE3 RULE19
        `RL_HUB_IDX: rl.hub_selector <= link.data; // RULE4
        `RL_ORBIT_IDX: rl.orbit_bcd <= {shift[7:0], link.data}; // RULE7 RULE5
        `RL_FLAGS_IDX: rl.east <= link.data[`EAST_FLAG_BIT]; // RULE8 RULE5
        `RL_FRAME_IDX: rl.frame_group_selector <= link.data; // RULE9
        default: rl <= rl;
      endcase
    end
  end
  // Whole record goes out at the last offset byte; a cut one never does
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      return_link_out <= '0;
      return_link_done_out <= 1'b0;
    end else if (rl_byte && idx == `RL_OFFSET_IDX) begin
      return_link_out <= '{rl.spacecraft_selector, rl.spot_number, rl.hub_selector, rl.orbit_bcd,
        rl.east, rl.frame_group_selector,
        link.broadcast ? 24'h000000 : {shift[15:0], link.data}, // RULE10 RULE11
        !link.broadcast}; // RULE11
      return_link_done_out <= 1'b1;
    end else begin
      return_link_done_out <= 1'b0;
    end
  end
  // ----------------------------------------
  // Private data
  // ----------------------------------------
  // Passed through untouched; meaning belongs to the operator
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      private_byte_out <= 8'h00;
      private_valid_out <= 1'b0;
    end else if (body_byte && state == ST_PRIV) begin
      private_byte_out <= link.data; // RULE12
      private_valid_out <= 1'b1;
    end else begin
      private_valid_out <= 1'b0;
    end
  end
  // ----------------------------------------
  // Table update outputs
  // ----------------------------------------
  // Even body bytes open a pair: network high byte or table code
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_byte <= 8'h00;
    end else if (tu_byte && idx[0] == 1'b0) begin
      first_byte <= link.data;
    end
  end
  // Network selector is handed on; matching it is the consumer's job
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      network_selector_out <= 16'h0000;
      network_valid_out <= 1'b0;
    end else if (tu_byte && idx == `TU_NET_IDX) begin
      network_selector_out <= {first_byte, link.data}; // RULE13 RULE19
      network_valid_out <= 1'b1;
    end else begin
      network_valid_out <= 1'b0;
    end
  end
  // Notices are hints only; section header version control stays elsewhere
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      changed_table_code_out <= 8'h00;
      new_version_out <= 5'h00;
      update_valid_out <= 1'b0;
    end else if (tu_byte && idx[0] == 1'b1 && idx != `TU_NET_IDX) begin
      changed_table_code_out <= first_byte; // RULE18
      new_version_out <= link.data[`VERSION_LSB +: `VERSION_W]; // RULE14 RULE5
      update_valid_out <= 1'b1; // RULE16
    end else begin
      update_valid_out <= 1'b0;
    end
  end
endmodule : desc_parser

// ==== hw/desc_parser_pkg.sv ====
package desc_parser_pkg;
  typedef enum logic [5:0] {
    ST_KIND = 6'h01,
    ST_LEN = 6'h02,
    ST_RL = 6'h04,
    ST_TU = 6'h08,
    ST_SKIP = 6'h10,
    ST_PRIV = 6'h20
  } parse_state_t;
  typedef struct packed {
    logic [7:0] spacecraft_selector;
    logic [15:0] spot_number;
    logic [7:0] hub_selector;
    logic [15:0] orbit_bcd;
    logic east;
    logic [7:0] frame_group_selector;
    logic [23:0] tx_offset;
    logic offset_valid;
  } return_link_t;
endpackage : desc_parser_pkg

// ==== hw/desc_parser_regs.svh ====
`ifndef DESC_PARSER_REGS_SVH
`define DESC_PARSER_REGS_SVH
// Overview of operation
// RULE1 - Kind byte, length byte, length bounds body
// RULE2 - First body byte is spacecraft selector
// RULE3 - Then 16-bit spot number
// RULE4 - Then hub selector, then reserved byte
// RULE5 - Reserved bits lead, sent and ignored
// RULE6 - Sender randomises reserved bits when encrypted
// RULE7 - Orbit position is four BCD digits
// RULE8 - Seven reserved bits, then east flag
// RULE9 - Extract 8-bit frame group selector
// RULE10 - Extract 24-bit signed offset, 100 Hz
// RULE11 - Broadcast message: offset disregarded
// RULE12 - Trailing bytes passed as private data
// RULE13 - Update body starts with network selector
// RULE14 - Entries: table code, 3 reserved, version
// RULE15 - Update parsing may be disabled
// RULE16 - Notices never replace version control
// RULE17 - Network skips notices for start-time shifts
// RULE18 - Any table code value accepted
// RULE19 - Fields assembled MSB first, arrival order
// RULE20 - Flag bad remaining length as error
`define KIND_RETURN_LINK 8'ha9
`define KIND_TABLE_UPDATE 8'haa
`define RL_FIXED_LEN 8'h0c
`define TU_FIXED_LEN 8'h02
`define TU_ENTRY_LEN 8'h02
`define EAST_FLAG_BIT 0
`define VERSION_LSB 0
`define VERSION_W 5
`define RL_SAT_IDX 8'h00
`define RL_SPOT_IDX 8'h02
`define RL_HUB_IDX 8'h03
`define RL_ORBIT_IDX 8'h06
`define RL_FLAGS_IDX 8'h07
`define RL_FRAME_IDX 8'h08
`define RL_OFFSET_IDX 8'h0b
`define TU_NET_IDX 8'h01
`endif

// ==== hw/desc_source.sv ====
`timescale 1ns/1ps
`include "desc_parser_regs.svh"
// Demultiplexer end: software pushes descriptor bytes one per write
module desc_source (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  desc_link_if.source link
);
  // ----------------------------------------
  // Byte push
  // ----------------------------------------
  // addr 0: body byte, addr 1: first byte of descriptor; addr 2: bit0 broadcast
  logic bcast;
  logic [7:0] sent;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.valid <= 1'b0;
      link.data <= 8'h00;
      link.start <= 1'b0;
    end else begin
      link.valid <= wr_in && (addr_in != 2'h2);
      link.start <= wr_in && (addr_in == 2'h1);
      link.data <= wdata_in; // RULE5 RULE6 reserved content chosen by software
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bcast <= 1'b0;
      sent <= 8'h00;
    end else begin
      if (wr_in && addr_in == 2'h2) begin
        bcast <= wdata_in[0];
      end
      if (wr_in && addr_in != 2'h2) begin
        sent <= sent + 8'h01;
      end
    end
  end
  assign link.broadcast = bcast;
  // Read back: byte count or broadcast mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= (addr_in == 2'h2) ? {7'h00, bcast} : sent;
    end
  end
endmodule : desc_source

// ==== sim/desc_parser_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------
// Link and result checks
// ----------------------------
module desc_parser_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic start,
  input wire logic broadcast,
  input wire desc_parser_pkg::return_link_t return_link_out,
  input wire logic return_link_done_out,
  input wire logic [7:0] private_byte_out,
  input wire logic private_valid_out,
  input wire logic [15:0] network_selector_out,
  input wire logic network_valid_out,
  input wire logic [4:0] new_version_out,
  input wire logic update_valid_out
);
  import desc_parser_pkg::*;
  logic [4:0] low5;
  // Version bits only, reserved bits dropped
  assign low5 = data[4:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // A return link spans 14 bytes, so done cannot repeat soon
  sequence done_s; return_link_done_out ##1 !return_link_done_out [*8]; endsequence
  start_byte_a: assert property (start |-> valid) else $error("start alone");
  done_gap_a: assert property (return_link_done_out |-> done_s) else $error("done twice");
  offset_low_a: assert property (return_link_done_out |-> $past(valid) &&
    return_link_out.tx_offset[7:0] == ($past(broadcast) ? 8'h00 : $past(data))) else $error("offset");
  offset_flag_a: assert property (return_link_done_out |->
    return_link_out.offset_valid != $past(broadcast)) else $error("offset flag");
  private_echo_a: assert property (private_valid_out |->
    $past(valid) && private_byte_out == $past(data)) else $error("private");
  net_low_a: assert property (network_valid_out |->
    $past(valid) && network_selector_out[7:0] == $past(data)) else $error("network");
  version_bits_a: assert property (update_valid_out |->
    $past(valid) && new_version_out == $past(low5)) else $error("version");
  update_gap_a: assert property (update_valid_out |=> !update_valid_out) else $error("update twice");
endmodule : desc_parser_monitor

// ==== sim/return_link_and_table_update_parser_bench.sv ====
`timescale 1ns/1ps
`include "desc_parser_regs.svh"
// ----------------------------
// Source feeds parser; notes queue scores results
// ----------------------------
module return_link_and_table_update_parser_bench;
  import desc_parser_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic update_enable_in = 1'b1;
  logic [7:0] rdata_out, private_byte_out, changed_table_code_out, sent = 8'h00;
  logic [15:0] network_selector_out;
  logic [4:0] new_version_out;
  logic return_link_done_out, private_valid_out, network_valid_out, update_valid_out, length_error_out;
  return_link_t return_link_out;
  logic [63:0] exp_q[$];
  logic [7:0] b[$];
  logic [31:0] r, s;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h9784;
  desc_link_if link();
  desc_source i_desc_source (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .link);
  desc_parser i_desc_parser (.clk_in, .rst_n_in, .link, .update_enable_in, .return_link_out,
    .return_link_done_out, .private_byte_out, .private_valid_out, .network_selector_out, .network_valid_out,
    .changed_table_code_out, .new_version_out, .update_valid_out, .length_error_out);
  desc_parser_monitor i_desc_parser_monitor (.clk_in, .rst_n_in, .valid(link.valid), .data(link.data),
    .start(link.start), .broadcast(link.broadcast), .return_link_out, .return_link_done_out, .private_byte_out,
    .private_valid_out, .network_selector_out, .network_valid_out, .new_version_out, .update_valid_out);
  always #2.5 clk_in = ~clk_in;
  task chk(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("Error %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task take(input logic [63:0] seen);
    chk(seen, exp_q.size() ? exp_q.pop_front() : 64'hx);
  endtask : take
  // Results sampled mid-cycle, matched oldest note first
  always @(negedge clk_in) begin
    if (return_link_done_out === 1'b1) begin
      take({return_link_out.spacecraft_selector, return_link_out.spot_number, return_link_out.hub_selector,
        return_link_out.frame_group_selector, return_link_out.tx_offset});
      take({4'h2, return_link_out.orbit_bcd, return_link_out.east, return_link_out.offset_valid});
    end
    if (private_valid_out === 1'b1) take({4'h5, private_byte_out});
    if (network_valid_out === 1'b1) take({4'h3, network_selector_out});
    if (update_valid_out === 1'b1) take({4'h4, changed_table_code_out, new_version_out});
    if (length_error_out === 1'b1) take(64'h6);
  end
  task put(input logic [1:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    if (a != 2'h2) sent = sent + 8'h01; // Address 3 pushes a byte as well
    @(posedge clk_in);
  endtask : put
  task send(input logic [7:0] kind);
    put(2'h1, kind);
    foreach (b[i]) put(2'h0, b[i]);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : send
  task rd(input logic [1:0] a, input logic [7:0] want);
    wr_in <= 1'b0;
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, want);
    @(posedge clk_in);
  endtask : rd
  // Random fields; reserved byte and flag bits random too
  task rl(input logic bc, input int np);
    r = $random(seed);
    s = $random(seed);
    put(2'h2, {7'h0, bc});
    b = {`RL_FIXED_LEN + 8'(np), r[31:24], r[23:16], r[15:8], r[7:0], s[31:24], s[23:16], s[15:8], s[7:0],
      r[15:8], s[15:8], s[7:0], r[31:24]};
    exp_q.push_back({r, r[15:8], bc ? 24'h0 : {s[15:0], r[31:24]}});
    exp_q.push_back({4'h2, s[23:8], s[0], !bc});
    for (int i = 0; i < np; i++) begin
      b.push_back(s[7:0] + 8'(i));
      exp_q.push_back({4'h5, s[7:0] + 8'(i)});
    end
    send(`KIND_RETURN_LINK);
  endtask : rl
  // Notices stand for real table changes, never bare start-time shifts
  task tu(input int n, input logic en);
    r = $random(seed);
    update_enable_in <= en;
    b = {`TU_FIXED_LEN + 8'(2 * n), r[31:24], r[23:16]};
    if (en) exp_q.push_back({4'h3, r[31:16]});
    for (int i = 0; i < n; i++) begin
      s = $random(seed);
      b.push_back(s[15:8]);
      b.push_back(s[7:0]);
      if (en) exp_q.push_back({4'h4, s[15:8], s[4:0]});
    end
    send(`KIND_TABLE_UPDATE);
  endtask : tu
  task final_report;
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Hang guard, far beyond the roughly 130 cycles needed
  initial begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rl(1'b0, 2);
    rl(1'b1, 0);
    tu(2, 1'b1);
    tu(3, 1'b0);
    tu(1, 1'b1);
    exp_q.push_back(64'h6);
    b = {8'h05, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    send(`KIND_RETURN_LINK);
    exp_q.push_back(64'h6);
    exp_q.push_back({4'h3, 16'h1234});
    b = {8'h03, 8'h12, 8'h34, 8'h9f};
    send(`KIND_TABLE_UPDATE);
    b = {8'h02, 8'ha9, 8'h0c};
    send(8'h42);
    b = {8'h0c, 8'h01, 8'h02};
    send(`KIND_RETURN_LINK);
    tu(1, 1'b1);
    rl(1'b0, 0);
    put(2'h3, 8'hff);
    rd(2'h2, 8'h00);
    rd(2'h3, sent);
    repeat (4) @(posedge clk_in);
    chk(exp_q.size(), 64'h0);
    final_report;
  end
endmodule : return_link_and_table_update_parser_bench
